// [src/cfg_header_command.sv]
// Purpose: Identification words and command register of one controller function
// Assumes: Configuration accesses arrive one per cycle at most, word indexed
// Notes:   Answer comes one cycle after the request; reads ignore byte enables
// What this block does
// - Standard header values, only product id differs
// - Fixed maker id at offset zero, writes ignored
// - Fixed product id, differs per function
// - All-zero command stops all non-config accesses
// - Command resets zero; bits 7,5,3 read-only
// - Bit 9 allows fast back-to-back across agents
// - Bit 8 gates the system error driver
// - Address parity reported needs bits 8 and 6
// - Parity response off: flag set, pin quiet
`include "cfg_header_params.svh"

module cfg_header_command #(
  parameter logic        ENHANCED_FUNCTION = 1'b0,    // 1 for the high-speed function
  parameter logic [15:0] MAKER_ID          = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID_FULL   = 16'ha5c1, // Arbitrary value
  parameter logic [15:0] PRODUCT_ID_HIGH   = 16'ha5c2  // Arbitrary value
) (
  input  wire logic                         ref_clk_in,     // System clock
  input  wire logic                         rst_in,         // Synchronous reset
  input  wire cfg_header_pkg::cfg_req_type  cfg_req_in,     // Configuration access
  output cfg_header_pkg::cfg_rsp_type       cfg_rsp_out,    // Configuration answer
  output cfg_header_pkg::cmd_type           cmd_out,        // Current command bits
  input  wire logic                         master_req_in,  // Core wants the bus
  input  wire logic                         mem_hit_in,     // Memory address decoded
  input  wire logic                         io_hit_in,      // I/O address decoded
  input  wire logic                         data_perr_in,   // Data parity error pulse
  input  wire logic                         addr_perr_in,   // Address parity error pulse
  input  wire logic                         parity_flag_clear_in, // Clear parity error flag
  output logic                              master_go_out,  // Mastering allowed now
  output logic                              mem_claim_out,  // Claim memory access
  output logic                              io_claim_out,   // Claim I/O access
  output logic                              b2b_cross_out,  // Cross-agent fast b2b ok
  output logic                              mwi_ok_out,     // Write-invalidate allowed
  output logic                              detected_parity_error_flag_out, // Sticky flag
  input  wire logic                         serr_n_in,      // System error pin level
  output logic                              serr_line_low_out, // Pin seen low
  output logic                              perr_n_out,     // Parity error pin out
  output logic                              perr_n_oe_out,  // Parity error enable
  output logic                              serr_n_out,     // System error pin out
  output logic                              serr_n_oe_out   // System error enable
);
  import cfg_header_pkg::*;

  // Whole block state
  typedef struct packed {
    cmd_type     cmd;
    cfg_rsp_type rsp;
    logic        detected_parity_error_flag; // Sticky, set wins over clear
    logic        master_go;
    logic        mem_claim;
    logic        io_claim;
    logic        b2b_cross;
    logic        mwi_ok;
    logic        serr_meta;   // First synchroniser stage, read only by the second
    logic        serr_low;
  } cmd_state_type;

  cmd_state_type s_q, s_d;
  logic [15:0]   product_id;  // Product id of this function
  logic [15:0]   lane_mask;   // Byte enables spread to bits
  logic [15:0]   cmd_bits;    // Command as a vector

  // Only the product id tells the two functions apart
  assign product_id = ENHANCED_FUNCTION ? PRODUCT_ID_HIGH : PRODUCT_ID_FULL;
  assign lane_mask  = {{8{cfg_req_in.byte_en[1]}}, {8{cfg_req_in.byte_en[0]}}};
  assign cmd_bits   = s_q.cmd;

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rsp.ack   = cfg_req_in.sel;       // Config cycles answered whatever the command
    s_d.rsp.rdata = 32'h0000_0000;
    if (cfg_req_in.sel && !cfg_req_in.write) begin
      // Read decode; unmapped words read zero
      if (cfg_req_in.index == `CFG_ID_INDEX) begin
        s_d.rsp.rdata = {product_id, MAKER_ID};
      end else if (cfg_req_in.index == `CFG_CMD_INDEX) begin
        s_d.rsp.rdata = {16'h0000, cmd_bits};
        s_d.rsp.rdata[16 + `STATUS_DETECTED_PARITY_ERROR_BIT] = s_q.detected_parity_error_flag;
      end
    end else if (cfg_req_in.sel && cfg_req_in.write) begin
      // Ids take no writes; only writable command bits move
      if (cfg_req_in.index == `CFG_CMD_INDEX) begin
        // Reserved and fixed bits are masked off, so stray ones do no harm
        s_d.cmd = cmd_type'((cmd_bits & ~(lane_mask & `CMD_WRITE_MASK))
                  | (cfg_req_in.wdata[15:0] & lane_mask & `CMD_WRITE_MASK));
      end
    end
    // Parity error flag: set wins over clear, set even with response off
    if (data_perr_in || addr_perr_in) begin
      s_d.detected_parity_error_flag = 1'b1;
    end else if (parity_flag_clear_in) begin
      s_d.detected_parity_error_flag = 1'b0;
    end
    // Gates; an all-zero command shuts every one of them
    s_d.master_go = master_req_in & s_q.cmd.bus_master_enable;
    s_d.mem_claim = mem_hit_in & s_q.cmd.memory_space_enable;
    s_d.io_claim  = io_hit_in & s_q.cmd.io_space_enable;
    s_d.b2b_cross = s_q.cmd.fast_b2b_enable;
    s_d.mwi_ok    = s_q.cmd.write_invalidate_enable;
    // Pin level crosses in through two flops
    s_d.serr_meta = ~serr_n_in;
    s_d.serr_low  = s_q.serr_meta;
  end

  // State register; command returns to zero on reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_q     <= '0;
      s_q.cmd <= cmd_type'(`CMD_RESET_VALUE);
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign cfg_rsp_out       = s_q.rsp;
  assign cmd_out           = s_q.cmd;
  assign master_go_out     = s_q.master_go;
  assign mem_claim_out     = s_q.mem_claim;
  assign io_claim_out      = s_q.io_claim;
  assign b2b_cross_out     = s_q.b2b_cross;
  assign mwi_ok_out        = s_q.mwi_ok;
  assign detected_parity_error_flag_out = s_q.detected_parity_error_flag;
  assign serr_line_low_out = s_q.serr_low;

  // Error pin drivers
  parity_error_reporter u_reporter (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .parity_rsp_in  (s_q.cmd.parity_error_response),
    .serr_drv_en_in (s_q.cmd.system_error_driver_enable),
    .data_perr_in   (data_perr_in),
    .addr_perr_in   (addr_perr_in),
    .perr_n_out     (perr_n_out),
    .perr_n_oe_out  (perr_n_oe_out),
    .serr_n_out     (serr_n_out),
    .serr_n_oe_out  (serr_n_oe_out)
  );

  // Write to the command word with both low byte enables set
  sequence cmd_write_s;
    cfg_req_in.sel && cfg_req_in.write && cfg_req_in.index == `CFG_CMD_INDEX
      && cfg_req_in.byte_en[1:0] == 2'b11;
  endsequence

  a_cmd_write: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cmd_write_s |=> cmd_out == cmd_type'($past(cfg_req_in.wdata[15:0]) & `CMD_WRITE_MASK))
    else $error("command write not stored through writable mask");

  a_fixed_bits: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !cmd_out.stepping_control && !cmd_out.palette_snoop && !cmd_out.special_cycle_monitor
      && cmd_out.reserved == 6'h00)
    else $error("read-only command bit set");

  a_id_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cfg_req_in.sel && !cfg_req_in.write && cfg_req_in.index == `CFG_ID_INDEX)
      |=> cfg_rsp_out.ack && cfg_rsp_out.rdata == {product_id, MAKER_ID})
    else $error("identifier read wrong");

  a_cmd_reset: assert property (@(posedge ref_clk_in)
    rst_in |=> cmd_out == cmd_type'(`CMD_RESET_VALUE))
    else $error("command not zero after reset");

  a_zero_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cmd_out == cmd_type'(16'h0000))[*2] |-> !mem_claim_out && !io_claim_out && !master_go_out)
    else $error("access claimed with command all zero");

  a_master_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    master_go_out |-> $past(master_req_in) && $past(cmd_out.bus_master_enable))
    else $error("bus mastering without enable");

  a_b2b_track: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    b2b_cross_out == $past(cmd_out.fast_b2b_enable))
    else $error("cross-agent fast b2b does not follow bit 9");

  a_flag_set: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (data_perr_in || addr_perr_in) |=> detected_parity_error_flag_out)
    else $error("parity error flag not set");

  // A clear with no event in the same cycle empties the flag
  a_flag_clear: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (parity_flag_clear_in && !data_perr_in && !addr_perr_in)
      |=> !detected_parity_error_flag_out)
    else $error("parity error flag not cleared");

  // Memory claims need the memory enable one cycle earlier
  a_mem_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    mem_claim_out |-> $past(mem_hit_in) && $past(cmd_out.memory_space_enable))
    else $error("memory access claimed without enable");

  // I/O claims need the I/O enable one cycle earlier
  a_io_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    io_claim_out |-> $past(io_hit_in) && $past(cmd_out.io_space_enable))
    else $error("io access claimed without enable");

  // Write-invalidate permission follows bit 4 one cycle late
  a_mwi_track: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    mwi_ok_out == $past(cmd_out.write_invalidate_enable))
    else $error("write-invalidate permission does not follow bit 4");

  // Read of the command word, then its answer one cycle on
  sequence cmd_read_s;
    cfg_req_in.sel && !cfg_req_in.write && cfg_req_in.index == `CFG_CMD_INDEX;
  endsequence

  // Answer carries the command and the flag as they stood at the request
  sequence cmd_answer_s;
    cfg_rsp_out.ack && cfg_rsp_out.rdata[15:0] == $past(cmd_out)
      && cfg_rsp_out.rdata[16 + `STATUS_DETECTED_PARITY_ERROR_BIT]
         == $past(detected_parity_error_flag_out);
  endsequence

  a_cmd_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cmd_read_s |=> cmd_answer_s)
    else $error("command word read wrong");

  // Config accesses keep being answered whatever the command holds
  a_cfg_answer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cfg_req_in.sel |=> cfg_rsp_out.ack)
    else $error("configuration access not answered");

  // Writes to the identifier word must leave the command alone
  a_id_nowrite: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (cfg_req_in.sel && cfg_req_in.write && cfg_req_in.index == `CFG_ID_INDEX)
      |=> cmd_out == $past(cmd_out))
    else $error("identifier write changed the command");

endmodule // cfg_header_command

// [src/cfg_header_params.svh]
// Purpose: Offsets, field positions, reset values and masks of the configuration header start
// Assumes: Configuration accesses address whole 32-bit words by index
// Notes:   Definitions only
`ifndef CFG_HEADER_PARAMS_SVH
`define CFG_HEADER_PARAMS_SVH

// Word indexes; byte offsets 00h (ids) and 04h (command)
`define CFG_ID_INDEX        6'h00
`define CFG_CMD_INDEX       6'h01

// Command bit positions
`define CMD_FAST_B2B_BIT    9
`define CMD_SERR_DRV_BIT    8
`define CMD_STEPPING_BIT    7
`define CMD_PARITY_RSP_BIT  6
`define CMD_PALETTE_BIT     5
`define CMD_WRITE_INV_BIT   4
`define CMD_SPECIAL_BIT     3
`define CMD_BUS_MASTER_BIT  2
`define CMD_MEMORY_BIT      1
`define CMD_IO_BIT          0

// Writable command bits: 9, 8, 6, 4, 2, 1, 0
`define CMD_WRITE_MASK      16'h0357
`define CMD_RESET_VALUE     16'h0000

// Detected parity error flag sits at bit 15 of the status half-word
`define STATUS_DETECTED_PARITY_ERROR_BIT 15

`endif

// [src/cfg_header_pkg.sv]
// Purpose: Types shared by the configuration header block
// Assumes: Nothing beyond the params header
// Notes:   Carriers are packed structs
package cfg_header_pkg;

  // Command register layout, msb first
  typedef struct packed {
    logic [5:0] reserved;
    logic       fast_b2b_enable;
    logic       system_error_driver_enable;
    logic       stepping_control;
    logic       parity_error_response;
    logic       palette_snoop;
    logic       write_invalidate_enable;
    logic       special_cycle_monitor;
    logic       bus_master_enable;
    logic       memory_space_enable;
    logic       io_space_enable;
  } cmd_type;

  // One configuration access request
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [5:0]  index;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } cfg_req_type;

  // One configuration answer
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } cfg_rsp_type;

endpackage : cfg_header_pkg

// [src/parity_error_reporter.sv]
// Purpose: Drives the open-drain parity and system error pins from parity events
// Assumes: Parity events are one-cycle pulses on the same clock
// Notes:   Pin out is always low; the enable carries the assertion
module parity_error_reporter (
  input  wire logic ref_clk_in,                 // System clock
  input  wire logic rst_in,                     // Synchronous reset, active high
  input  wire logic parity_rsp_in,              // Parity error response enable
  input  wire logic serr_drv_en_in,             // System error driver enable
  input  wire logic data_perr_in,               // Data parity error pulse
  input  wire logic addr_perr_in,               // Address parity error pulse
  output logic      perr_n_out,                 // Parity error pin level
  output logic      perr_n_oe_out,              // High while driving parity error
  output logic      serr_n_out,                 // System error pin level
  output logic      serr_n_oe_out               // High while driving system error
);
  import cfg_header_pkg::*;

  typedef struct packed {
    logic perr_oe;
    logic serr_oe;
  } rep_state_type;

  rep_state_type s_q, s_d;

  // Next state: both pins released unless an enabled event arrives
  always_comb begin
    s_d = '0;
    s_d.perr_oe = data_perr_in & parity_rsp_in;
    // Address errors need both enables; the driver gate closes otherwise
    s_d.serr_oe = addr_perr_in & parity_rsp_in & serr_drv_en_in;
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign perr_n_out    = 1'b0;          // Open drain, only the enable moves
  assign perr_n_oe_out = s_q.perr_oe;
  assign serr_n_out    = 1'b0;
  assign serr_n_oe_out = s_q.serr_oe;

  // System error only follows an address error with both enables set
  a_serr_cause: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    serr_n_oe_out |-> $past(addr_perr_in) && $past(parity_rsp_in) && $past(serr_drv_en_in))
    else $error("system error driven without enabled address parity error");

  // Driver stays off while its enable is clear
  a_serr_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !serr_drv_en_in |=> !serr_n_oe_out)
    else $error("system error driver active while disabled");

  // Parity pin quiet while parity response is off
  a_perr_quiet: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (data_perr_in && !parity_rsp_in) |=> !perr_n_oe_out)
    else $error("parity error pin driven with response off");

endmodule // parity_error_reporter

// [verif/pci_pin_model.sv]
// Purpose: Bus side of the open-drain parity and system error wires
// Assumes: Both wires carry a pull-up on the bus
// Notes:   Another agent may pull the system error wire low at will
module pci_pin_model (
  input  wire logic serr_drive_in,  // Device pin level
  input  wire logic serr_oe_in,     // Device drives system error
  input  wire logic perr_drive_in,  // Device pin level
  input  wire logic perr_oe_in,     // Device drives parity error
  input  wire logic other_pull_in,  // Another agent pulls system error low
  output logic      serr_wire_out,  // Resolved system error wire
  output logic      perr_wire_out   // Resolved parity error wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // Released wires float up to the pull-up level, never the last value
  assign serr_wire_out = (serr_oe_in ? serr_drive_in : 1'b1) & ~other_pull_in;
  assign perr_wire_out = perr_oe_in ? perr_drive_in : 1'b1;
endmodule // pci_pin_model

// [verif/test_pci_config_header_command.sv]
// Purpose: Self-checking bench for the identification words and command register
// Assumes: Inputs change on the falling edge; answers are sampled there
// Notes:   Identity values are arbitrary; both functions are built side by side
module test_pci_config_header_command;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_header_pkg::*;

  localparam logic [15:0] MAKER = 16'h3c3c; // Arbitrary value
  localparam logic [15:0] PFULL = 16'h7e01; // Arbitrary value
  localparam logic [15:0] PHIGH = 16'h7e02; // Arbitrary value

  logic        ref_clk_in = 1'b0;  // Bench clock
  logic        rst_in     = 1'b1;  // Bench reset
  cfg_req_type cfg_req    = '0;    // Configuration request
  cfg_rsp_type cfg_rsp;            // Configuration answer
  cfg_rsp_type rsp_full;           // Answer of the full-speed function
  cmd_type     cmd;                // Command bits seen
  logic        mreq = 1'b0, mhit = 1'b0, ihit = 1'b0;   // Core requests
  logic        dperr = 1'b0, aperr = 1'b0, clr = 1'b0;  // Parity events
  logic        other_pull = 1'b0;                       // Foreign pull-down
  logic        mgo, mclaim, iclaim, b2b, mwi, pflag, low_seen;
  logic        perr_d, perr_oe, serr_d, serr_oe, serr_wire, perr_wire;
  logic [31:0] rd;                 // Last read data
  logic [31:0] rd_full;            // Last read data, full-speed function
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  initial forever #10 ref_clk_in = ~ref_clk_in;

  cfg_header_command #(.ENHANCED_FUNCTION(1'b1), .MAKER_ID(MAKER),
    .PRODUCT_ID_FULL(PFULL), .PRODUCT_ID_HIGH(PHIGH)) u_cfg_header_command (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_req_in(cfg_req),
    .cfg_rsp_out(cfg_rsp), .cmd_out(cmd), .master_req_in(mreq),
    .mem_hit_in(mhit), .io_hit_in(ihit), .data_perr_in(dperr),
    .addr_perr_in(aperr), .parity_flag_clear_in(clr), .master_go_out(mgo),
    .mem_claim_out(mclaim), .io_claim_out(iclaim), .b2b_cross_out(b2b),
    .mwi_ok_out(mwi), .detected_parity_error_flag_out(pflag), .serr_n_in(serr_wire),
    .serr_line_low_out(low_seen), .perr_n_out(perr_d), .perr_n_oe_out(perr_oe),
    .serr_n_out(serr_d), .serr_n_oe_out(serr_oe));

  // Full-speed function on the same request, only its identifier is compared
  cfg_header_command #(.ENHANCED_FUNCTION(1'b0), .MAKER_ID(MAKER),
    .PRODUCT_ID_FULL(PFULL), .PRODUCT_ID_HIGH(PHIGH)) u_cfg_header_command_full (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_req_in(cfg_req),
    .cfg_rsp_out(rsp_full), .cmd_out(), .master_req_in(mreq),
    .mem_hit_in(mhit), .io_hit_in(ihit), .data_perr_in(dperr),
    .addr_perr_in(aperr), .parity_flag_clear_in(clr), .master_go_out(),
    .mem_claim_out(), .io_claim_out(), .b2b_cross_out(),
    .mwi_ok_out(), .detected_parity_error_flag_out(), .serr_n_in(serr_wire),
    .serr_line_low_out(), .perr_n_out(), .perr_n_oe_out(),
    .serr_n_out(), .serr_n_oe_out());

  pci_pin_model u_pci_pin_model (
    .serr_drive_in(serr_d), .serr_oe_in(serr_oe), .perr_drive_in(perr_d),
    .perr_oe_in(perr_oe), .other_pull_in(other_pull),
    .serr_wire_out(serr_wire), .perr_wire_out(perr_wire));

  // Verdict and end of run, shared by the main sequence and the watchdog
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One comparison; four-state so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  // One configuration access: held across the taking edge, answer one cycle on
  task automatic cfg(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                     input logic [31:0] wd);
    @(negedge ref_clk_in);
    cfg_req <= '{sel: 1'b1, write: wr, index: idx, byte_en: be, wdata: wd};
    @(negedge ref_clk_in);
    cfg_req <= '0;
    chk("ack", 32'h1, {31'h0, cfg_rsp.ack});
    rd = cfg_rsp.rdata;
    rd_full = rsp_full.rdata;
  endtask

  // Watchdog: the whole sequence needs under a hundred cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      close_out();
    end
  end

  // Parity cases: command, data error, address error, expected {perr oe, serr oe}
  logic [15:0] pc_cmd [4] = '{16'h0000, 16'h0040, 16'h0100, 16'h0140};
  logic        pc_d   [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic        pc_a   [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic [1:0]  pc_exp [4] = '{2'b00, 2'b10, 2'b00, 2'b01};

  // Main sequence
  initial begin
    repeat (20) @(negedge ref_clk_in);
    rst_in <= 1'b0;
    chk("cmd reset", 32'h0, {16'h0, cmd});
    cfg(1'b0, 6'h00, 4'hf, 32'h0);
    chk("ids", {PHIGH, MAKER}, rd);
    chk("ids full", {PFULL, MAKER}, rd_full);
    cfg(1'b1, 6'h00, 4'hf, 32'hffffffff);
    cfg(1'b0, 6'h00, 4'hf, 32'h0);
    chk("ids after write", {PHIGH, MAKER}, rd);
    cfg(1'b0, 6'h05, 4'hf, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Low byte only: upper enables must leave bits 9 and 8 clear
    cfg(1'b1, 6'h01, 4'h1, 32'h000003ff);
    chk("low byte", 32'h0057, {16'h0, cmd});
    cfg(1'b1, 6'h01, 4'h3, 32'h000003ff);
    chk("cmd mask", 32'h0357, {16'h0, cmd});
    @(negedge ref_clk_in);
    chk("b2b mwi", 32'h3, {30'h0, b2b, mwi});
    cfg(1'b0, 6'h01, 4'hf, 32'h0);
    chk("cmd read", 32'h0357, rd);
    // Each enable alone opens only its own gate
    mreq <= 1'b1;
    mhit <= 1'b1;
    ihit <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cfg(1'b1, 6'h01, 4'h3, 32'h1 << i);
      @(negedge ref_clk_in);
      chk("gates", 32'h1 << i, {29'h0, mgo, mclaim, iclaim});
    end
    cfg(1'b1, 6'h01, 4'h3, 32'h0);
    @(negedge ref_clk_in);
    chk("all off", 32'h0, {28'h0, mgo, mclaim, iclaim, b2b});
    cfg(1'b0, 6'h00, 4'hf, 32'h0);
    chk("cfg while off", {PHIGH, MAKER}, rd);
    // Parity reporting against the two enables
    for (int i = 0; i < 4; i++) begin
      cfg(1'b1, 6'h01, 4'h3, {16'h0, pc_cmd[i]});
      @(negedge ref_clk_in);
      dperr <= pc_d[i];
      aperr <= pc_a[i];
      @(negedge ref_clk_in);
      dperr <= 1'b0;
      aperr <= 1'b0;
      chk("pin drive", {30'h0, pc_exp[i]}, {30'h0, perr_oe, serr_oe});
      chk("wires", {30'h0, ~pc_exp[i]}, {30'h0, perr_wire, serr_wire});
      cfg(1'b0, 6'h01, 4'hf, 32'h0);
      chk("status", {1'b1, 15'h0, pc_cmd[i]}, rd);
      @(negedge ref_clk_in);
      clr <= 1'b1;
      @(negedge ref_clk_in);
      clr <= 1'b0;
      chk("flag clear", 32'h0, {31'h0, pflag});
    end
    // Another agent pulls the system error wire
    other_pull <= 1'b1;
    repeat (3) @(negedge ref_clk_in);
    chk("serr seen", 32'h1, {31'h0, low_seen});
    other_pull <= 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk("serr gone", 32'h0, {31'h0, low_seen});
    // Event and clear in one cycle: the set wins
    @(negedge ref_clk_in);
    dperr <= 1'b1;
    clr   <= 1'b1;
    @(negedge ref_clk_in);
    dperr <= 1'b0;
    clr   <= 1'b0;
    chk("set beats clear", 32'h1, {31'h0, pflag});
    // Mid-run reset brings command, flag and copies back to zero
    cfg(1'b1, 6'h01, 4'h3, 32'h00000357);
    @(negedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(negedge ref_clk_in);
    rst_in <= 1'b0;
    chk("cmd re-reset", 32'h0, {16'h0, cmd});
    chk("flag re-reset", 32'h0, {30'h0, pflag, b2b});
    cfg(1'b0, 6'h01, 4'hf, 32'h0);
    chk("cmd read re-reset", 32'h0, rd);
    close_out();
  end
endmodule // test_pci_config_header_command
